//--- rtl/tws_pkg.sv
// shared constants, types and helpers of the three-wire serial port
package tws_pkg;

	// =====================================================================
	// widths and counts
	localparam int unsigned BYTE_BITS     = 8;
	localparam logic [3:0]  CNT_DONE      = 4'h8;
	localparam logic [3:0]  CNT_LAST      = 4'h7;
	localparam logic [3:0]  CNT_ZERO      = 4'h0;
	localparam logic [3:0]  CNT_STEP      = 4'h1;
	localparam logic [4:0]  HALF_TOGGLES  = 5'h10;
	localparam logic [4:0]  HALF_STEP     = 5'h01;

	// =====================================================================
	// configuration encodings and reset values
	localparam logic [2:0]  SLAVE_CLK_SEL = 3'h7;
	localparam logic [7:0]  BYTE_RESET    = 8'h00;

	// =====================================================================
	// types
	typedef logic [BYTE_BITS-1:0] tws_byte_type;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_PEND   = 4'b0010,
		ST_RUN    = 4'b0100,
		ST_FINISH = 4'b1000
	} tws_state_type;

	// =====================================================================
	// first bit on the line for a given bit order
	function automatic logic tws_first_bit(tws_byte_type d, logic lsb_first);
		tws_first_bit = lsb_first ? d[0] : d[BYTE_BITS-1];
	endfunction

endpackage

//--- rtl/tws_link_if.sv
// signals between the core and the serial-clock side of the port
`timescale 1ns/10ps
interface tws_link_if;
	import tws_pkg::*;

	logic         cap_clk;
	logic         run;
	logic         dir;
	logic         si;
	tws_byte_type tx;
	tws_byte_type rx;
	logic         out_bit;
	logic         started;
	logic         done;

	modport core (
		output cap_clk,
		output run,
		output dir,
		output si,
		output tx,
		input  rx,
		input  out_bit,
		input  started,
		input  done
	);

	modport link (
		input  cap_clk,
		input  run,
		input  dir,
		input  si,
		input  tx,
		output rx,
		output out_bit,
		output started,
		output done
	);
endinterface

//--- rtl/tws_link.sv
// shift engine that runs on the serial clock
`timescale 1ns/10ps
module tws_link (
	tws_link_if.link lnk
);
	import tws_pkg::*;

	// =====================================================================
	// capture side: shift and count on the rising edge of the capture clock
	typedef struct packed {
		logic [3:0]   cnt;
		tws_byte_type sr;
		logic         done;
	} tws_cap_type;

	typedef struct packed {
		logic bit_v;
		logic started;
	} tws_launch_type;

	tws_cap_type    cap_ff;
	tws_cap_type    nxt_cap;
	tws_launch_type launch_ff;
	tws_launch_type nxt_launch;
	tws_byte_type   base;

	// first capture takes the buffer, later ones the running register
	always_comb begin
		nxt_cap = cap_ff;
		base    = (cap_ff.cnt == CNT_ZERO) ? lnk.tx : cap_ff.sr;
		if (cap_ff.cnt != CNT_DONE) begin
			nxt_cap.sr   = lnk.dir ? {lnk.si, base[BYTE_BITS-1:1]}
			                       : {base[BYTE_BITS-2:0], lnk.si};
			nxt_cap.cnt  = cap_ff.cnt + CNT_STEP;
			nxt_cap.done = (cap_ff.cnt == CNT_LAST);
		end
	end

	// run low holds the engine cleared; it is also the start crossing
	always_ff @(posedge lnk.cap_clk or negedge lnk.run) begin
		if (!lnk.run) begin
			cap_ff <= '0;
		end else begin
			cap_ff <= nxt_cap;
		end
	end

	// =====================================================================
	// launch side: output latch on the opposite edge of the capture clock
	// extra slave edges after the byte leave the last bit standing
	always_comb begin
		nxt_launch = launch_ff;
		if (cap_ff.cnt != CNT_DONE) begin
			nxt_launch.started = 1'b1;
			if (cap_ff.cnt == CNT_ZERO) begin
				nxt_launch.bit_v = tws_first_bit(lnk.tx, lnk.dir);
			end else begin
				nxt_launch.bit_v = lnk.dir ? cap_ff.sr[0]
				                           : cap_ff.sr[BYTE_BITS-1];
			end
		end
	end

	always_ff @(negedge lnk.cap_clk or negedge lnk.run) begin
		if (!lnk.run) begin
			launch_ff <= '0;
		end else begin
			launch_ff <= nxt_launch;
		end
	end

	// =====================================================================
	// results toward the core
	assign lnk.rx      = cap_ff.sr;
	assign lnk.done    = cap_ff.done;
	assign lnk.out_bit = launch_ff.bit_v;
	assign lnk.started = launch_ff.started;

endmodule

//--- rtl/tws_three_wire_serial_port.sv
// byte-wide three-wire serial port, master or slave, with slave select
//
// Contract
// - whole bytes, bits shifted with serial clock
// - transmit mode: buffer write starts exchange
// - receive-only: shift register read starts reception
// - slave select low lets request start
// - slave select high holds request pending
// - pending request starts when select goes low
// - select high during transfer suspends it
// - slave select honoured only on slave
// - busy flag set once request is taken, even while it is held pending
// - after eight bits: done flag, busy clears
// - phase zero: first bit on first edge
// - phase zero: later bits on same edges
// - phase one: first bit at strobe end
// - phase one: later bits on opposite edge
// - data output holds last bit afterwards
// - disable clears busy and shift register
// - disabled phase one shows first buffer bit (transmit mode only; receive-only stays low)
`timescale 1ns/10ps
module tws_three_wire_serial_port #(
	parameter bit          HAS_SLAVE_SELECT = 1'b1,
	parameter int unsigned SCK_HALF_BASE    = 4,
	parameter int unsigned DIV_W            = 12
) (
	input  wire logic                  clock,
	input  wire logic                  reset_n,
	input  wire logic                  unit_enable_bit,
	input  wire logic                  transfer_mode_bit,
	input  wire logic                  slave_select_enable_bit,
	input  wire logic                  clock_polarity_bit,
	input  wire logic                  data_phase_bit,
	input  wire logic                  bit_order_bit,
	input  wire logic [2:0]            clock_source_sel,
	input  wire logic                  tx_write_strobe,
	input  wire tws_pkg::tws_byte_type transmit_buffer_wdata,
	input  wire logic                  rx_read_strobe,
	input  wire logic                  irq_clear,
	output tws_pkg::tws_byte_type      transmit_buffer,
	output tws_pkg::tws_byte_type      serial_shift_register,
	output logic                       transfer_busy_flag,
	output logic                       transfer_done_irq_flag,
	input  wire logic                  serial_clock_pin_in,
	output logic                       serial_clock_pin_out,
	output logic                       serial_clock_pin_oe,
	input  wire logic                  serial_data_in,
	output logic                       serial_data_out,
	output logic                       serial_data_oe,
	input  wire logic                  slave_select_input
);
	import tws_pkg::*;

	// =====================================================================
	// core state, all in one register
	typedef struct packed {
		tws_state_type    state;
		tws_byte_type     tx;
		tws_byte_type     rx;
		logic             busy;
		logic             irq;
		logic             run;
		logic             so;
		logic             sck;
		logic             sck_oe;
		logic             so_oe;
		logic [DIV_W-1:0] div;
		logic [4:0]       half;
		logic             done_s1;
		logic             done_s2;
		logic             ss_s1;
		logic             ss_s2;
	} tws_core_type;

	localparam tws_core_type CORE_RESET = '{
		state   : ST_IDLE,
		tx      : BYTE_RESET,
		rx      : BYTE_RESET,
		ss_s1   : 1'b1,
		ss_s2   : 1'b1,
		default : '0
	};

	tws_core_type     st_ff;
	tws_core_type     nxt_st;

	logic             slave_mode;
	logic             select_used;
	logic             select_ok;
	logic             start_req;
	logic             idle_level;
	logic             master_done;
	logic [DIV_W-1:0] half_len;
	logic             first_new;

	tws_link_if lnk ();

	// =====================================================================
	// shift engine on the serial clock
	tws_link u_link (
		.lnk (lnk)
	);

	// =====================================================================
	// decoded configuration
	// a source select of all ones means the clock arrives from outside
	assign slave_mode  = (clock_source_sel == SLAVE_CLK_SEL);
	// select pin only matters on the instance that has it, as a slave
	assign select_used = HAS_SLAVE_SELECT && slave_mode
	                     && slave_select_enable_bit;
	assign select_ok   = !select_used || !st_ff.ss_s2;
	// which software access opens a transfer depends on the mode
	assign start_req   = transfer_mode_bit ? tx_write_strobe
	                                       : rx_read_strobe;
	// low polarity idles high, launching on falling edges with phase zero and rising edges with phase one
	assign idle_level  = !clock_polarity_bit;
	assign half_len    = DIV_W'(SCK_HALF_BASE) << clock_source_sel;
	assign master_done = (st_ff.half == HALF_TOGGLES);
	// first bit of whatever byte the starting access leaves in the buffer
	assign first_new   = tws_first_bit(tx_write_strobe ? transmit_buffer_wdata : st_ff.tx,
	                                   bit_order_bit);

	// =====================================================================
	// link connections; the engine clock is the pin, turned so that
	// receive capture is always its rising edge and output its falling
	assign lnk.cap_clk = serial_clock_pin_in ^ clock_polarity_bit ^ data_phase_bit;
	// clearing the enable clears the engine at once, not at a clock edge
	assign lnk.run     = st_ff.run & unit_enable_bit;
	assign lnk.dir     = bit_order_bit;
	assign lnk.si      = serial_data_in;
	assign lnk.tx      = st_ff.tx;

	// =====================================================================
	// next-state logic
	always_comb begin
		nxt_st = st_ff;

		// level crossings into this clock: done from the link, select pin
		nxt_st.done_s1 = lnk.done;
		nxt_st.done_s2 = st_ff.done_s1;
		nxt_st.ss_s1   = slave_select_input;
		nxt_st.ss_s2   = st_ff.ss_s1;

		// pin directions: clock driven only as master, data only transmitting
		nxt_st.sck_oe = unit_enable_bit && !slave_mode;
		nxt_st.so_oe  = unit_enable_bit && transfer_mode_bit;

		// buffer accepts writes only between transfers
		if (tx_write_strobe && !st_ff.busy) begin
			nxt_st.tx = transmit_buffer_wdata;
		end

		// software clear first, so a completion in the same cycle wins
		if (irq_clear) begin
			nxt_st.irq = 1'b0;
		end

		case (st_ff.state)
			ST_IDLE: begin
				nxt_st.sck = idle_level;
				if (start_req) begin
					nxt_st.busy = 1'b1;
					nxt_st.half = '0;
					nxt_st.div  = half_len;
					// with phase one the first bit leaves when the access ends
					if (data_phase_bit) begin
						nxt_st.so = first_new;
					end
					if (select_ok) begin
						nxt_st.run   = 1'b1;
						nxt_st.state = ST_RUN;
					end else begin
						nxt_st.state = ST_PEND;
					end
				end
			end

			ST_PEND: begin
				nxt_st.sck = idle_level;
				if (select_ok) begin
					nxt_st.run   = 1'b1;
					nxt_st.state = ST_RUN;
				end
			end

			ST_RUN: begin
				if (!select_ok) begin
					// suspend: the engine is held clear and the byte restarts
					nxt_st.run   = 1'b0;
					nxt_st.sck   = idle_level;
					nxt_st.state = ST_PEND;
				end else if (!slave_mode) begin
					// master: sixteen half periods make eight pulses
					if (st_ff.div == '0) begin
						nxt_st.div = half_len;
						if (!master_done) begin
							nxt_st.sck  = !st_ff.sck;
							nxt_st.half = st_ff.half + HALF_STEP;
						end
					end else begin
						nxt_st.div = st_ff.div - DIV_W'(1);
					end
					if (master_done && st_ff.done_s2) begin
						nxt_st.state = ST_FINISH;
					end
				end else if (st_ff.done_s2) begin
					nxt_st.state = ST_FINISH;
				end
			end

			ST_FINISH: begin
				// engine is quiet after its eighth capture, so its words are stable
				nxt_st.rx    = lnk.rx;
				nxt_st.so    = lnk.started ? lnk.out_bit : st_ff.so;
				nxt_st.busy  = 1'b0;
				nxt_st.irq   = 1'b1;
				nxt_st.run   = 1'b0;
				nxt_st.sck   = idle_level;
				nxt_st.state = ST_IDLE;
			end

			default: begin
				nxt_st.state = ST_IDLE;
			end
		endcase

		// disabled: everything stops; with phase one in transmit mode the output shows the buffer's first bit, otherwise it is low
		if (!unit_enable_bit) begin
			nxt_st.state = ST_IDLE;
			nxt_st.busy  = 1'b0;
			nxt_st.run   = 1'b0;
			nxt_st.rx    = BYTE_RESET;
			nxt_st.sck   = idle_level;
			nxt_st.so    = transfer_mode_bit && data_phase_bit
			               && tws_first_bit(st_ff.tx, bit_order_bit);
		end
	end

	// =====================================================================
	// state register
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st_ff <= CORE_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// =====================================================================
	// outputs
	assign transmit_buffer        = st_ff.tx;
	assign serial_shift_register  = st_ff.rx;
	assign transfer_busy_flag     = st_ff.busy;
	assign transfer_done_irq_flag = st_ff.irq;
	assign serial_clock_pin_out   = st_ff.sck;
	assign serial_clock_pin_oe    = st_ff.sck_oe;
	assign serial_data_oe         = st_ff.so_oe;

	// during a frame the engine's latch drives the line once it has
	// launched; before that and after, the held bit stands. receive-only
	// mode keeps the line low. the mux saves a crossing that would
	// otherwise delay every bit by two core cycles.
	assign serial_data_out = transfer_mode_bit
	                         && (lnk.started ? lnk.out_bit : st_ff.so);

endmodule

//--- bench/tws_monitor.sv
// concurrent checks on the serial port's top-level ports
`timescale 1ns/10ps
module tws_monitor (
	input wire logic                  clock,
	input wire logic                  reset_n,
	input wire logic                  unit_enable_bit,
	input wire logic                  transfer_mode_bit,
	input wire logic                  clock_polarity_bit,
	input wire logic [2:0]            clock_source_sel,
	input wire logic                  tx_write_strobe,
	input wire logic                  rx_read_strobe,
	input wire tws_pkg::tws_byte_type serial_shift_register,
	input wire logic                  transfer_busy_flag,
	input wire logic                  transfer_done_irq_flag,
	input wire logic                  serial_clock_pin_out,
	input wire logic                  serial_clock_pin_oe,
	input wire logic                  serial_data_out,
	input wire logic                  serial_data_oe
);
	import tws_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);

	// =====================================================================
	// start requests taken while idle
	sequence s_wr_req;
		!transfer_busy_flag && unit_enable_bit && transfer_mode_bit && tx_write_strobe;
	endsequence
	sequence s_rd_req;
		!transfer_busy_flag && unit_enable_bit && !transfer_mode_bit && rx_read_strobe;
	endsequence

	// =====================================================================
	// assertions
	a_busy_on_write: assert property (s_wr_req |=> transfer_busy_flag)
		else $error("busy not set after buffer write");
	a_busy_on_read: assert property (s_rd_req |=> transfer_busy_flag)
		else $error("busy not set after receive read");
	a_done_ends_busy: assert property ($rose(transfer_done_irq_flag) |-> $fell(transfer_busy_flag))
		else $error("done flag without busy clearing");
	a_disable_clears_all: assert property (!unit_enable_bit |=>
		!transfer_busy_flag && serial_shift_register == BYTE_RESET)
		else $error("disable left busy or shift data");
	// enable checked twice: a disable also drops busy and may change the line
	a_last_bit_holds: assert property ($fell(transfer_busy_flag) && unit_enable_bit &&
		$past(unit_enable_bit) && transfer_mode_bit |->
		$stable(serial_data_out) ##1 $stable(serial_data_out))
		else $error("data line moved after completion");
	a_sck_idle_level: assert property (serial_clock_pin_oe && $past(serial_clock_pin_oe) &&
		!transfer_busy_flag && $stable(clock_polarity_bit) |->
		serial_clock_pin_out == !clock_polarity_bit)
		else $error("serial clock not at idle level");
	a_sck_oe_master: assert property ($past(reset_n) |-> serial_clock_pin_oe ==
		$past(unit_enable_bit && clock_source_sel != SLAVE_CLK_SEL))
		else $error("clock drive enable wrong for mode");
	a_data_oe_mode: assert property ($past(reset_n) |-> serial_data_oe ==
		$past(unit_enable_bit && transfer_mode_bit))
		else $error("data drive enable wrong for mode");
	a_rx_only_low: assert property (!transfer_mode_bit |-> !serial_data_out)
		else $error("data line not low in receive only");
endmodule

//--- bench/tws_peer.sv
// far-side peripheral: answers a byte, records what it hears, clocks a slave port
`timescale 1ns/10ps
module tws_peer (
	input  wire logic sck,
	input  wire logic mosi,
	input  wire logic ckp,
	input  wire logic dap,
	input  wire logic lsb,
	output logic      miso,
	output logic      sck_drv
);
	import tws_pkg::*;
	tws_byte_type reply;
	tws_byte_type got;
	int           cnt;
	logic         run;
	logic         lvl;
	wire          clk_c = sck ^ ckp ^ dap;

	// clock stands at its idle level outside a frame
	assign sck_drv = run ? lvl : !ckp;

	function automatic int pos(input int k);
		return lsb ? k : 7 - k;
	endfunction

	initial begin
		run = 1'b0;
		lvl = 1'b0;
		cnt = 8;
		miso = 1'b0;
		got = 8'h00;
	end

	task automatic arm(input tws_byte_type r);
		reply = r;
		got = 8'h00;
		cnt = 0;
		miso = r[pos(0)];
	endtask

	// n toggles at 64 ns period, phase unrelated to the core clock
	task automatic burst(input int n);
		#7;
		lvl = !ckp;
		run = 1'b1;
		repeat (n) begin
			#32;
			lvl = !lvl;
		end
		#32;
		run = 1'b0;
	endtask

	// capture edge; 2 ns after the eighth bit the line is inverted, so no stale level
	always @(posedge clk_c) begin
		if (cnt < 8) begin
			got[pos(cnt)] = mosi;
			cnt = cnt + 1;
			if (cnt == 8)
				miso <= #2 !miso;
		end
	end

	// launch edge: present the next reply bit
	always @(negedge clk_c) begin
		if (cnt < 8)
			miso <= reply[pos(cnt)];
	end
endmodule

//--- bench/tws_three_wire_serial_port_tb_top.sv
// self-checking bench of the three-wire serial port and its far-side peer
`timescale 1ns/10ps
module tws_three_wire_serial_port_tb_top;
	import tws_pkg::*;
	logic         clock, reset_n, en, mode, sse, ckp, dap, lsb, wr, rd, iclr, ss_n;
	logic [2:0]   sel;
	tws_byte_type wdata, tbuf, srx;
	logic         busy, irq, sck_o, sck_oe, sdo, sdo_oe, miso, peer_sck;
	int           bad_count, samples_checked;
	// the wire follows whichever party drives the clock
	wire          sck_w = sck_oe ? sck_o : peer_sck;

	tws_three_wire_serial_port dut_u (
		.clock(clock), .reset_n(reset_n), .unit_enable_bit(en), .transfer_mode_bit(mode),
		.slave_select_enable_bit(sse), .clock_polarity_bit(ckp), .data_phase_bit(dap),
		.bit_order_bit(lsb), .clock_source_sel(sel), .tx_write_strobe(wr),
		.transmit_buffer_wdata(wdata), .rx_read_strobe(rd), .irq_clear(iclr),
		.transmit_buffer(tbuf), .serial_shift_register(srx), .transfer_busy_flag(busy),
		.transfer_done_irq_flag(irq), .serial_clock_pin_in(sck_w),
		.serial_clock_pin_out(sck_o), .serial_clock_pin_oe(sck_oe), .serial_data_in(miso),
		.serial_data_out(sdo), .serial_data_oe(sdo_oe), .slave_select_input(ss_n)
	);
	tws_peer peer_u (
		.sck(sck_w), .mosi(sdo), .ckp(ckp), .dap(dap), .lsb(lsb), .miso(miso),
		.sck_drv(peer_sck)
	);

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// =====================================================================
	// shared tasks
	task automatic chk(input string what, input tws_byte_type exp, input tws_byte_type got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic cfg(input logic p, input logic ph, input logic o, input logic [2:0] s,
		input logic m);
		@(posedge clock);
		ckp <= p;
		dap <= ph;
		lsb <= o;
		sel <= s;
		mode <= m;
		repeat (2) @(posedge clock);
	endtask

	// one-cycle software strobe; busy is sampled a step after the taking edge
	task automatic strobe(input logic is_rd, input tws_byte_type d);
		@(posedge clock);
		wr <= !is_rd;
		rd <= is_rd;
		wdata <= d;
		@(posedge clock);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
	endtask

	// bounded wait for completion, then the flag is cleared; no access while busy
	task automatic wait_irq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 3000) begin
			@(posedge clock);
			#1;
			n++;
		end
		chk("done flag", 1'b1, irq);
		chk("busy at done", 1'b0, busy);
		@(posedge clock);
		iclr <= 1'b1;
		@(posedge clock);
		iclr <= 1'b0;
	endtask

	// =====================================================================
	// scenarios
	task automatic t_master(input logic p, input logic ph, input logic o, input tws_byte_type d,
		input tws_byte_type r);
		cfg(p, ph, o, 3'h0, 1'b1);
		peer_u.arm(r);
		strobe(1'b0, d);
		chk("busy", 1'b1, busy);
		strobe(1'b0, ~d); // refused while busy
		chk("buffer", d, tbuf);
		wait_irq();
		chk("received", r, srx);
		chk("peer heard", d, peer_u.got);
		chk("pulses", 8'h08, peer_u.cnt[7:0]);
		chk("clock idle", !p, sck_o);
		chk("last bit", o ? d[7] : d[0], sdo);
	endtask

	task automatic t_rx_only();
		cfg(1'b0, 1'b0, 1'b0, 3'h0, 1'b0);
		peer_u.arm(8'h5a);
		strobe(1'b0, 8'h11);
		chk("write in rx only", 1'b0, busy);
		strobe(1'b1, 8'h00);
		chk("busy", 1'b1, busy);
		wait_irq();
		chk("received", 8'h5a, srx);
	endtask

	task automatic t_disable();
		cfg(1'b0, 1'b1, 1'b0, 3'h0, 1'b1);
		peer_u.arm(8'h00);
		strobe(1'b0, 8'h82);
		repeat (20) @(posedge clock);
		en <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		chk("busy off", 1'b0, busy);
		chk("shift off", 8'h00, srx);
		chk("msb shown", 1'b1, sdo);
		@(posedge clock);
		lsb <= 1'b1;
		repeat (2) @(posedge clock);
		#1;
		chk("lsb shown", 1'b0, sdo);
		en <= 1'b1;
	endtask

	task automatic t_slave_pending();
		cfg(1'b0, 1'b0, 1'b0, 3'h7, 1'b1);
		peer_u.arm(8'h3e);
		strobe(1'b0, 8'hd4);
		peer_u.burst(16);
		repeat (4) @(posedge clock);
		#1;
		chk("held", 1'b0, irq);
		ss_n <= 1'b0;
		repeat (4) @(posedge clock);
		peer_u.arm(8'h3e);
		peer_u.burst(16);
		wait_irq();
		chk("received", 8'h3e, srx);
		chk("peer heard", 8'hd4, peer_u.got);
	endtask

	task automatic t_slave_suspend();
		peer_u.arm(8'h71);
		strobe(1'b0, 8'h2b);
		peer_u.burst(8);
		@(posedge clock);
		ss_n <= 1'b1;
		repeat (6) @(posedge clock);
		#1;
		chk("still busy", 1'b1, busy);
		chk("no done", 1'b0, irq);
		ss_n <= 1'b0;
		repeat (4) @(posedge clock);
		peer_u.arm(8'h71);
		peer_u.burst(16);
		wait_irq();
		chk("received", 8'h71, srx);
		chk("peer heard", 8'h2b, peer_u.got);
		// select ignored when its enable is off, even with the pin high
		@(posedge clock);
		sse <= 1'b0;
		ss_n <= 1'b1;
		repeat (4) @(posedge clock);
		peer_u.arm(8'h9c);
		strobe(1'b0, 8'h63);
		chk("busy no select", 1'b1, busy);
		repeat (4) @(posedge clock);
		peer_u.burst(16);
		wait_irq();
		chk("received no select", 8'h9c, srx);
		chk("peer heard no select", 8'h63, peer_u.got);
	endtask

	// =====================================================================
	// main sequence and watchdog
	initial begin
		{reset_n, en, mode, sse, ckp, dap, lsb, wr, rd, iclr, sel, wdata} = '0;
		ss_n = 1'b1;
		bad_count = 0;
		samples_checked = 0;
		repeat (8) @(posedge clock);
		reset_n <= 1'b1;
		repeat (2) @(posedge clock);
		#1;
		chk("reset busy", 1'b0, busy);
		chk("reset shift", 8'h00, srx);
		en <= 1'b1;
		sse <= 1'b1;
		for (int i = 0; i < 8; i++)
			t_master(i[0], i[1], i[2], 8'h96 ^ 8'(i), 8'hc5 - 8'(i));
		t_rx_only();
		t_disable();
		t_slave_pending();
		t_slave_suspend();
		tally_and_finish();
	end

	initial begin
		#200000;
		bad_count++;
		tally_and_finish();
	end
endmodule

bind tws_three_wire_serial_port tws_monitor mon_u (
	.clock, .reset_n, .unit_enable_bit, .transfer_mode_bit, .clock_polarity_bit,
	.clock_source_sel, .tx_write_strobe, .rx_read_strobe, .serial_shift_register,
	.transfer_busy_flag, .transfer_done_irq_flag, .serial_clock_pin_out,
	.serial_clock_pin_oe, .serial_data_out, .serial_data_oe
);
